/* design/coproc_resp_handler.sv */
// Main-processor side of the coprocessor response dialogue, with an AXI4-Lite slave.
// Assumes the interface port acknowledges each request with a one-cycle cpi_ack pulse,
// and the exception unit acknowledges an interrupt service request with int_ack.
//
// The register addresses and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
module coproc_resp_handler import coproc_resp_pkg::*; (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Coprocessor interface register port
	output cpi_req_t cpi_out,
	input wire logic cpi_ack,
	input wire logic [31:0] cpi_rdata,
	// Exception unit
	input wire logic irq_pending,
	output int_req_t int_out,
	input wire logic int_ack,
	// Interrupt
	output logic irq
);
	state_t st_reg, st_next;
	logic [PRIM_W-1:0] prim_reg;
	logic pc_done_reg, cond_reg, cond_next, after_restart_reg, after_restart_next;
	logic int_mid_reg, int_mid_next;
	logic [EV_W-1:0] evt_reg, evt_next, stat_reg, stat_next, mask_reg;
	logic [CTRL_W-1:0] ctrl_reg;
	logic [31:0] pc_reg;
	logic aw_have, w_have;
	logic [7:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic do_write, ar_take, start, stat_clr;
	logic f_again, f_pcf, f_int_ok, f_finished, f_true, is_null, is_busy, need_pass, cond_mode, trace;

	assign f_again = prim_reg[AGAIN_BIT];
	assign f_pcf = prim_reg[PCF_BIT];
	assign f_int_ok = prim_reg[INT_OK_BIT];
	assign f_finished = prim_reg[FINISHED_BIT];
	assign f_true = prim_reg[TRUE_BIT];
	assign is_null = prim_reg[TYPE_HI:TYPE_LO] == TYPE_NULL;
	assign is_busy = prim_reg[TYPE_HI:TYPE_LO] == TYPE_BUSY;
	// flag counts as cleared once passed
	assign need_pass = f_pcf && !pc_done_reg;
	assign cond_mode = ctrl_reg[CTRL_COND];
	assign trace = ctrl_reg[CTRL_TRACE];
	assign do_write = aw_have && w_have && !s_axi_bvalid;
	assign ar_take = s_axi_arvalid && s_axi_arready;
	// Start only from idle; a start while busy is dropped
	assign start = do_write && awaddr_reg == REG_CTRL && wstrb_reg[0]
		&& wdata_reg[CTRL_START] && st_reg == S_IDLE;

	// Dialogue sequencing
	always_comb begin
		st_next = st_reg;
		evt_next = '0;
		cond_next = cond_reg;
		after_restart_next = after_restart_reg;
		int_mid_next = int_mid_reg;
		unique case (st_reg)
			S_IDLE: if (start) st_next = S_READ;
			S_READ: if (cpi_ack) st_next = S_DECODE;
			S_PASS: if (cpi_ack) st_next = S_DECODE;
			S_INT: if (int_ack) begin
				if (after_restart_reg) begin
					st_next = S_IDLE;
					evt_next[EV_RESTART] = 1'b1;
					evt_next[EV_BKPT] = ctrl_reg[CTRL_BKPT];
				end else begin
					st_next = S_READ;
				end
			end
			S_DECODE: begin
				if (need_pass) begin
					st_next = S_PASS;
				end else if (is_busy) begin
					if (irq_pending) begin
						st_next = S_INT;
						int_mid_next = 1'b0;
						after_restart_next = 1'b1;
					end else begin
						st_next = S_IDLE;
						evt_next[EV_RESTART] = 1'b1;
					end
				end else if (is_null && f_again) begin
					st_next = (f_int_ok && irq_pending) ? S_INT : S_READ;
					int_mid_next = 1'b1;
					after_restart_next = 1'b0;
				end else if (is_null && cond_mode) begin
					st_next = S_IDLE;
					evt_next[EV_DONE] = 1'b1;
					cond_next = f_true;
				end else if (is_null && trace && !f_finished) begin
					st_next = (f_int_ok && irq_pending) ? S_INT : S_READ;
					int_mid_next = 1'b1;
					after_restart_next = 1'b0;
				end else if (is_null) begin
					st_next = S_IDLE;
					evt_next[EV_DONE] = 1'b1;
					evt_next[EV_TRACE] = trace;
				end else begin
					st_next = S_IDLE;
					evt_next[EV_PROTO] = 1'b1;
				end
			end
		endcase
	end

	// Dialogue state and latched primitive
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			st_reg <= S_IDLE;
			prim_reg <= '0;
			pc_done_reg <= 1'b0;
			cond_reg <= 1'b0;
			after_restart_reg <= 1'b0;
			int_mid_reg <= 1'b0;
			evt_reg <= '0;
		end else begin
			st_reg <= st_next;
			cond_reg <= cond_next;
			after_restart_reg <= after_restart_next;
			int_mid_reg <= int_mid_next;
			evt_reg <= evt_next;
			// whole primitive word from the response register
			if (st_reg == S_READ && cpi_ack) begin
				prim_reg <= cpi_rdata[PRIM_W-1:0];
				pc_done_reg <= 1'b0;
			end else if (st_reg == S_PASS && cpi_ack) begin
				pc_done_reg <= 1'b1;
			end
		end
	end

	// Interface and interrupt requests, registered from the next state
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			cpi_out <= '0;
			int_out <= '0;
		end else begin
			cpi_out.req <= st_next == S_READ || st_next == S_PASS;
			cpi_out.we <= st_next == S_PASS;
			cpi_out.addr <= (st_next == S_PASS) ? INSN_ADDR_OFF : RESP_WORD_OFF;
			cpi_out.wdata <= pc_reg;
			int_out.req <= st_next == S_INT;
			int_out.mid_frame <= int_mid_next;
		end
	end

	// AXI write channels; address and data taken in either order
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			s_axi_awready <= 1'b1;
			s_axi_wready <= 1'b1;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
			aw_have <= 1'b0;
			w_have <= 1'b0;
			awaddr_reg <= '0;
			wdata_reg <= '0;
			wstrb_reg <= '0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_have <= 1'b1;
				awaddr_reg <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_have <= 1'b1;
				wdata_reg <= s_axi_wdata;
				wstrb_reg <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				aw_have <= 1'b0;
				w_have <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (awaddr_reg == REG_CTRL || awaddr_reg == REG_PC
					|| awaddr_reg == REG_STATE || awaddr_reg == REG_IRQ_STAT
					|| awaddr_reg == REG_IRQ_MASK) ? RESP_OKAY : RESP_SLVERR;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				s_axi_awready <= 1'b1;
				s_axi_wready <= 1'b1;
			end
		end
	end

	// Writable registers; status and state are read-only
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			ctrl_reg <= CTRL_RST;
			pc_reg <= PC_RST;
			mask_reg <= MASK_RST;
		end else if (do_write) begin
			if (awaddr_reg == REG_CTRL && wstrb_reg[0])
				ctrl_reg <= {wdata_reg[CTRL_W-1:1], 1'b0};
			if (awaddr_reg == REG_IRQ_MASK && wstrb_reg[0])
				mask_reg <= wdata_reg[EV_W-1:0];
			// Byte lanes honoured on the program counter
			for (int i = 0; i < 4; i++) begin
				if (awaddr_reg == REG_PC && wstrb_reg[i])
					pc_reg[8*i +: 8] <= wdata_reg[8*i +: 8];
			end
		end
	end

	// AXI read channel; answer one cycle after the address
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= '0;
			s_axi_rresp <= RESP_OKAY;
		end else if (ar_take) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= RESP_OKAY;
			unique case (s_axi_araddr)
				REG_CTRL: s_axi_rdata <= {28'h0, ctrl_reg};
				REG_PC: s_axi_rdata <= pc_reg;
				// direction flag shown with the primitive
				REG_STATE: s_axi_rdata <= {prim_reg, 8'h00, prim_reg[DIR_BIT],
					cond_reg, st_reg == S_IDLE ? 1'b0 : 1'b1, st_reg};
				REG_IRQ_STAT: s_axi_rdata <= {27'h0, stat_reg};
				REG_IRQ_MASK: s_axi_rdata <= {27'h0, mask_reg};
				default: begin
					s_axi_rdata <= '0;
					s_axi_rresp <= RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// Sticky events; a read clears them, a same-cycle event survives
	assign stat_clr = ar_take && s_axi_araddr == REG_IRQ_STAT;
	assign stat_next = (stat_reg & (stat_clr ? '0 : stat_reg)) | evt_reg;
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			stat_reg <= '0;
			irq <= 1'b0;
		end else begin
			stat_reg <= stat_next;
			irq <= |(stat_next & mask_reg);
		end
	end

	// Checks
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);
	logic go;
	assign go = st_reg == S_DECODE && !need_pass;

	property p_prim_word;
		st_reg == S_READ && cpi_ack |=> prim_reg == $past(cpi_rdata[PRIM_W-1:0]);
	endproperty
	a_prim_word: assert property (p_prim_word) else $error("primitive not latched");
	property p_pass_first;
		st_reg == S_DECODE && need_pass |=> cpi_out.req && cpi_out.we
			&& cpi_out.addr == INSN_ADDR_OFF && cpi_out.wdata == $past(pc_reg);
	endproperty
	a_pass_first: assert property (p_pass_first) else $error("counter not passed first");
	property p_reread;
		go && is_null && f_again && !f_int_ok |=> st_reg == S_READ && cpi_out.req && !cpi_out.we;
	endproperty
	a_reread: assert property (p_reread) else $error("come-again without reread");
	property p_busy_int;
		go && is_busy && irq_pending |=> int_out.req && !int_out.mid_frame;
	endproperty
	a_busy_int: assert property (p_busy_int) else $error("busy without preinstruction service");
	property p_null_int;
		go && is_null && f_again && f_int_ok && irq_pending |=> int_out.req && int_out.mid_frame;
	endproperty
	a_null_int: assert property (p_null_int) else $error("null without midinstruction service");
	property p_cond_end;
		go && is_null && !f_again && cond_mode |=> evt_reg[EV_DONE] && cond_reg == $past(f_true);
	endproperty
	a_cond_end: assert property (p_cond_end) else $error("conditional result wrong");
	property p_gen_end;
		go && is_null && !f_again && !cond_mode && !trace |=> evt_reg[EV_DONE] ##1 !evt_reg[EV_DONE];
	endproperty
	a_gen_end: assert property (p_gen_end) else $error("general dialogue not ended");
	property p_trace_wait;
		go && is_null && !f_again && !cond_mode && trace && !f_finished |=> !evt_reg[EV_DONE]
			&& st_reg != S_IDLE;
	endproperty
	a_trace_wait: assert property (p_trace_wait) else $error("trace ended early");
	property p_undef;
		go && !is_null && !is_busy |=> evt_reg[EV_PROTO] && st_reg == S_IDLE;
	endproperty
	a_undef: assert property (p_undef) else $error("undefined primitive accepted");
	property p_bkpt;
		st_reg == S_INT && int_ack && after_restart_reg && ctrl_reg[CTRL_BKPT]
			|=> evt_reg[EV_BKPT] && evt_reg[EV_RESTART];
	endproperty
	a_bkpt: assert property (p_bkpt) else $error("breakpoint not repeated");
endmodule

/* design/coproc_resp_pkg.sv */
// Constants, types and register map for the coprocessor response primitive handler.
// Assumes a 32-bit AXI4-Lite register bus and a simple request/acknowledge interface port.
package coproc_resp_pkg;
	// Primitive word and its common option bits
	localparam int PRIM_W = 16;
	localparam int AGAIN_BIT = 15;
	localparam int PCF_BIT = 14;
	localparam int DIR_BIT = 13;
	// Per-primitive field layout
	localparam int TYPE_HI = 12;
	localparam int TYPE_LO = 9;
	localparam int INT_OK_BIT = 8;
	localparam int FINISHED_BIT = 1;
	localparam int TRUE_BIT = 0;
	localparam logic [3:0] TYPE_NULL = 4'h4;
	localparam logic [3:0] TYPE_BUSY = 4'h2;
	// Offsets inside the coprocessor interface register set
	localparam logic [4:0] RESP_WORD_OFF = 5'h00;
	localparam logic [4:0] INSN_ADDR_OFF = 5'h18;
	// AXI register byte offsets
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_PC = 8'h04;
	localparam logic [7:0] REG_STATE = 8'h08;
	localparam logic [7:0] REG_IRQ_STAT = 8'h0c;
	localparam logic [7:0] REG_IRQ_MASK = 8'h10;
	// Control register bits
	localparam int CTRL_START = 0;
	localparam int CTRL_COND = 1;
	localparam int CTRL_TRACE = 2;
	localparam int CTRL_BKPT = 3;
	localparam int CTRL_W = 4;
	// Event bits, shared by status and mask
	localparam int EV_DONE = 0;
	localparam int EV_RESTART = 1;
	localparam int EV_PROTO = 2;
	localparam int EV_TRACE = 3;
	localparam int EV_BKPT = 4;
	localparam int EV_W = 5;
	// Reset values
	localparam logic [CTRL_W-1:0] CTRL_RST = 4'h0;
	localparam logic [31:0] PC_RST = 32'h0000_0000;
	localparam logic [EV_W-1:0] MASK_RST = 5'h00;
	// Bus answers
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Dialogue states
	typedef enum logic [4:0] {
		S_IDLE = 5'h01,
		S_READ = 5'h02,
		S_DECODE = 5'h04,
		S_PASS = 5'h08,
		S_INT = 5'h10
	} state_t;
	// Access request toward the coprocessor interface registers
	typedef struct packed {
		logic req;
		logic we;
		logic [4:0] addr;
		logic [31:0] wdata;
	} cpi_req_t;
	// Interrupt service request toward the exception unit
	typedef struct packed {
		logic req;
		logic mid_frame;
	} int_req_t;
endpackage

/* sim/coproc_model.sv */
// Coprocessor stand-in: answers response reads and instruction address writes.
// Assumes the bench fills prim_q and reads the counters by hierarchical name.
`timescale 1ns/1ps
module coproc_model import coproc_resp_pkg::*; (
	// Clock and reset
	input wire logic clock,
	input wire logic sys_rst,
	// Interface register port
	input wire cpi_req_t cpi_out,
	output logic cpi_ack,
	output logic [31:0] cpi_rdata
);
	logic [15:0] prim_q[$];
	logic [15:0] p;
	logic [31:0] pc_seen = 32'h0;
	logic owe_pc = 1'b0;
	int dly = 0;
	int wait_cnt = 0;
	int reads = 0;
	int pc_writes = 0;
	int order_err = 0;
	// Idle data toggles, so a late sample never looks valid
	always @(posedge clock) begin
		cpi_ack <= 1'b0;
		cpi_rdata <= ~cpi_rdata;
		if (sys_rst) begin
			cpi_rdata <= 32'h0;
			owe_pc <= 1'b0;
			wait_cnt = 0;
		end else if (cpi_out.req && !cpi_ack) begin
			if (wait_cnt < dly) begin
				wait_cnt++;
			end else begin
				wait_cnt = 0;
				cpi_ack <= 1'b1;
				if (cpi_out.we !== owe_pc ||
						cpi_out.addr !== (cpi_out.we ? INSN_ADDR_OFF : RESP_WORD_OFF))
					order_err++;
				if (cpi_out.we) begin
					pc_seen <= cpi_out.wdata;
					pc_writes++;
					owe_pc <= 1'b0;
				end else begin
					p = (prim_q.size() > 0) ? prim_q.pop_front() : 16'h0000;
					cpi_rdata <= {16'ha5a5, p};
					owe_pc <= p[PCF_BIT];
					reads++;
				end
			end
		end
	end
endmodule

/* sim/coproc_response_primitive_handler_tb.sv */
// Bench for the response primitive handler: AXI4-Lite tasks and dialogue runs.
// Assumes coproc_model on the interface port and a one-pulse interrupt unit here.
`timescale 1ns/1ps
module coproc_response_primitive_handler_tb import coproc_resp_pkg::*;;
	logic clock = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, irq_pending = 1'b0, int_ack = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic cpi_ack, irq, last_mid;
	logic [1:0] s_axi_bresp, s_axi_rresp, rs;
	logic [31:0] s_axi_rdata, cpi_rdata, rd;
	logic [4:0] mask = 5'h1f;
	cpi_req_t cpi_out;
	int_req_t int_out;
	int errors = 0, num_checks = 0, ints = 0, i;
	coproc_resp_handler DUT (.clock, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cpi_out, .cpi_ack, .cpi_rdata,
		.irq_pending, .int_out, .int_ack, .irq);
	coproc_model cop (.clock, .sys_rst, .cpi_out, .cpi_ack, .cpi_rdata);
	initial forever #4 clock = ~clock;
	// Interrupt unit stand-in, acknowledges each service request at once
	always @(posedge clock) begin
		int_ack <= 1'b0;
		if (int_out.req === 1'b1 && !int_ack) begin
			int_ack <= 1'b1;
			last_mid <= int_out.mid_frame;
			ints++;
		end
	end
	task automatic end_of_test;
		if (errors == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		@(posedge clock);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		for (n = 0; n < 200; n++) begin
			@(posedge clock);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		if (n == 200) errors++;
		if (n == 200) end_of_test();
		s_axi_bready <= 1'b0;
		chk({30'h0, s_axi_bresp}, {30'h0, er});
	endtask
	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		@(posedge clock);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		for (n = 0; n < 200; n++) begin
			@(posedge clock);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		if (n == 200) errors++;
		if (n == 200) end_of_test();
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
		axi_read(a, rd, rs);
		chk(rd, exp);
	endtask
	// Start a dialogue, wait for it to end, then check events and the interrupt line
	task automatic run(input logic [3:0] ctrl, input logic [4:0] exp_stat);
		int n;
		axi_write(REG_CTRL, {28'h0, ctrl}, RESP_OKAY);
		for (n = 0; n < 50; n++) begin
			axi_read(REG_STATE, rd, rs);
			if (rd[5] === 1'b0) break;
		end
		if (n == 50) errors++;
		if (n == 50) end_of_test();
		repeat (2) @(posedge clock);
		chk({31'h0, irq}, {31'h0, |(exp_stat & mask)});
		rchk(REG_IRQ_STAT, {27'h0, exp_stat});
		repeat (2) @(posedge clock);
		chk({31'h0, irq}, 32'h0);
	endtask
	task automatic clr;
		cop.reads = 0;
		cop.pc_writes = 0;
		ints = 0;
	endtask
	initial begin
		repeat (20) @(posedge clock);
		sys_rst <= 1'b0;
		// Reset values, bus errors and masks
		rchk(REG_CTRL, 32'h0);
		rchk(REG_PC, PC_RST);
		rchk(REG_STATE, 32'h1);
		rchk(REG_IRQ_STAT, 32'h0);
		rchk(REG_IRQ_MASK, 32'h0);
		axi_read(8'h40, rd, rs);
		chk({rd[31:2], rs}, {30'h0, RESP_SLVERR});
		axi_write(8'h40, 32'h1, RESP_SLVERR);
		axi_write(REG_IRQ_MASK, {27'h0, mask}, RESP_OKAY);
		rchk(REG_IRQ_MASK, 32'h1f);
		axi_write(REG_PC, 32'h0001_2344, RESP_OKAY);
		rchk(REG_PC, 32'h0001_2344);
		// General: pass-counter first, come-again without interrupts, direction set
		irq_pending <= 1'b1;
		cop.prim_q = '{16'hc800, 16'h8800, 16'h2800};
		run(4'h1, 5'h01);
		chk(cop.pc_seen, 32'h0001_2344);
		chk(cop.pc_writes, 32'd1);
		chk(cop.reads, 32'd3);
		chk(ints, 32'd0);
		axi_read(REG_STATE, rd, rs);
		chk(rd & 32'hffff_00bf, 32'h2800_0081);
		// Conditional: condition result taken, finished flag ignored; then interrupt, busy, trace and protocol-error runs
		for (i = 0; i < 2; i++) begin
			clr();
			cop.prim_q = '{(i == 0) ? 16'h0801 : 16'h0802};
			run(4'h3, 5'h01);
			axi_read(REG_STATE, rd, rs);
			chk({31'h0, rd[6]}, 32'(i == 0));
		end
		clr();
		cop.prim_q = '{16'h8900, 16'h0800};
		run(4'h1, 5'h01);
		chk(ints, 32'd1);
		chk({31'h0, last_mid}, 32'd1);
		chk(cop.reads, 32'd2);
		clr();
		cop.prim_q = '{16'h0400};
		run(4'h9, 5'h12);
		chk(ints, 32'd1);
		chk({31'h0, last_mid}, 32'd0);
		chk(cop.reads, 32'd1);
		clr();
		irq_pending <= 1'b0;
		cop.prim_q = '{16'h0400};
		run(4'h1, 5'h02);
		chk(ints, 0);
		clr();
		irq_pending <= 1'b1;
		cop.prim_q = '{16'h0900, 16'h0800, 16'h0802};
		run(4'h5, 5'h09);
		chk(ints, 32'd1);
		chk(cop.reads, 32'd3);
		clr();
		cop.prim_q = '{16'h4000};
		run(4'h1, 5'h04);
		chk(cop.pc_writes, 1);
		// Slow coprocessor, completion event masked
		clr();
		mask = 5'h1e;
		axi_write(REG_IRQ_MASK, {27'h0, mask}, RESP_OKAY);
		cop.dly = 3;
		cop.prim_q = '{16'hc800, 16'h0800};
		run(4'h1, 5'h01);
		chk(cop.order_err, 0);
		end_of_test();
	end
endmodule
